/* File: rtl/feac_pkg.sv */
// constants for the alarm codeword controller
package feac_pkg;
    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [7:0] ADDR_CONTROL = 8'h60;
    localparam logic [7:0] ADDR_STATUS = 8'h61;
    localparam logic [7:0] ADDR_LATCHED = 8'h62;
    localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h63;
    localparam logic [7:0] ADDR_CODEWORD_A = 8'h64;
    localparam logic [7:0] ADDR_CODEWORD_B = 8'h65;
    localparam logic [7:0] ADDR_RX_HEAD = 8'h66;
    localparam logic [7:0] ADDR_MASTER_IRQ = 8'h67;
    // ****************************************
    // field positions
    // ****************************************
    localparam int BIT_TX_IDLE = 0;
    localparam int BIT_RX_DETECT = 1;
    localparam int BIT_RX_IDLE = 2;
    localparam int BIT_RX_NONEMPTY = 3;
    localparam int BIT_RX_OVERFLOW = 4;
    localparam int BIT_RX_EMPTY = 3;
    localparam int BIT_RX_RESET = 2;
    localparam int BIT_MASTER_IRQ = 0;
    // ****************************************
    // reset values and sizes
    // ****************************************
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [5:0] RESET_WORD = 6'h00;
    localparam logic [1:0] SELECT_IDLE = 2'h0;
    localparam logic [1:0] SELECT_A_ONCE = 2'h1;
    localparam logic [1:0] SELECT_A_THEN_B = 2'h2;
    localparam logic [1:0] SELECT_A_LOOP = 2'h3;
    localparam int QUEUE_DEPTH = 4;
    localparam logic [3:0] REPEAT_COUNT = 4'h9;
    localparam logic [3:0] FRAME_LAST = 4'hf;
    localparam logic [1:0] VALID_COUNT = 2'h2;
    localparam logic [4:0] IDLE_ONES = 5'h10;
    // ****************************************
    // transmit sequencer states
    // ****************************************
    typedef enum logic [1:0] {
        TX_IDLE, TX_SEND_A, TX_SEND_B, TX_LOOP_A
    } feac_tx_state_type;
endpackage : feac_pkg

/* File: rtl/feac_rx_queue.sv */
// four-entry queue of validated receive codewords
module feac_rx_queue
    import feac_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic flush,
    // write side
    input wire logic push,
    input wire logic [5:0] push_word,
    // read side
    input wire logic pop,
    output logic [5:0] head_word,
    output logic empty,
    output logic full
);
    logic [5:0] store [QUEUE_DEPTH];
    logic [1:0] rd_ptr;
    logic [1:0] wr_ptr;
    logic [2:0] count;
    wire do_push = push && !full;
    wire do_pop = pop && !empty;
    assign empty = (count == 3'h0);
    assign full = (count == 3'h4);
    assign head_word = store[rd_ptr];
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_ptr <= 2'h0;
            wr_ptr <= 2'h0;
            count <= 3'h0;
            for (int i = 0; i < QUEUE_DEPTH; i++) store[i] <= RESET_WORD;
        end else if (flush) begin
            rd_ptr <= 2'h0;
            wr_ptr <= 2'h0;
            count <= 3'h0;
        end else begin
            if (do_push) begin
                store[wr_ptr] <= push_word;
                wr_ptr <= wr_ptr + 2'h1;
            end
            if (do_pop) rd_ptr <= rd_ptr + 2'h1;
            if (do_push && !do_pop) count <= count + 3'h1;
            else if (do_pop && !do_push) count <= count - 3'h1;
        end
    end
endmodule // feac_rx_queue

/* File: rtl/feac_ctrl.sv */
// alarm codeword controller: transmit, receive, registers, interrupt
//
// Chosen here: the plain strobed port.
module feac_ctrl
    import feac_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    // alarm channel bit stream, one bit per enable
    input wire logic bit_enable,
    input wire logic rx_bit,
    output logic tx_bit,
    // interrupt
    output logic irq
);
    // ****************************************
    // reset release
    // ****************************************
    logic rst_meta;
    logic rst_n;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // ****************************************
    // register decode
    // ****************************************
    logic [1:0] tx_codeword_select;
    logic rx_reset_bit;
    logic [4:0] alarm_code_irq_enable;
    logic alarm_code_master_irq_en;
    logic [5:0] codeword_a_bits;
    logic [5:0] codeword_b_bits;
    logic [4:0] alarm_code_latched_status;
    wire wr_control = reg_write && reg_addr == ADDR_CONTROL;
    wire wr_latched = reg_write && reg_addr == ADDR_LATCHED;
    wire wr_enable = reg_write && reg_addr == ADDR_IRQ_ENABLE;
    wire wr_code_a = reg_write && reg_addr == ADDR_CODEWORD_A;
    wire wr_code_b = reg_write && reg_addr == ADDR_CODEWORD_B;
    wire wr_master = reg_write && reg_addr == ADDR_MASTER_IRQ;
    wire rd_head = reg_read && reg_addr == ADDR_RX_HEAD;
    wire [4:0] clear_mask = wr_latched ? reg_wdata[4:0] : 5'h00;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_codeword_select <= SELECT_IDLE;
            rx_reset_bit <= 1'b0;
            alarm_code_irq_enable <= RESET_BYTE[4:0];
            alarm_code_master_irq_en <= 1'b0;
            codeword_a_bits <= RESET_WORD;
            codeword_b_bits <= RESET_WORD;
        end else begin
            if (wr_control) tx_codeword_select <= reg_wdata[1:0];
            if (wr_control) rx_reset_bit <= reg_wdata[BIT_RX_RESET];
            if (wr_enable) alarm_code_irq_enable <= reg_wdata[4:0];
            if (wr_master) alarm_code_master_irq_en <= reg_wdata[0];
            if (wr_code_a) codeword_a_bits <= reg_wdata[5:0];
            if (wr_code_b) codeword_b_bits <= reg_wdata[5:0];
        end
    end

    // ****************************************
    // transmitter
    // ****************************************
    feac_tx_state_type tx_state;
    logic [1:0] select_prev;
    logic [3:0] tx_pos;
    logic [3:0] tx_reps;
    logic [5:0] tx_word;
    logic select_mode_b;
    wire select_start = select_prev == SELECT_IDLE &&
                        tx_codeword_select != SELECT_IDLE;
    wire frame_end = bit_enable && tx_pos == FRAME_LAST;
    wire tx_busy = tx_state != TX_IDLE;
    wire reps_done = tx_reps == REPEAT_COUNT;

    // frame bit at position: 0-7 ones, 8 zero, 9-14 data, 15 zero
    function automatic logic frame_bit(input logic [3:0] pos,
                                       input logic [5:0] word);
        logic [3:0] idx;
        idx = pos - 4'h9;
        if (pos < 4'h8) frame_bit = 1'b1;
        else if (pos == 4'h8 || pos == FRAME_LAST) frame_bit = 1'b0;
        else frame_bit = word[idx[2:0]];
    endfunction

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_state <= TX_IDLE;
            select_prev <= SELECT_IDLE;
            tx_pos <= 4'h0;
            tx_reps <= 4'h0;
            tx_word <= RESET_WORD;
            tx_bit <= 1'b1;
        end else begin
            select_prev <= tx_codeword_select;
            if (bit_enable) begin
                tx_bit <= tx_busy ? frame_bit(tx_pos, tx_word) : 1'b1;
                if (tx_busy) tx_pos <= tx_pos + 4'h1;
            end
            case (tx_state)
                TX_IDLE: begin
                    tx_pos <= 4'h0;
                    tx_reps <= 4'h0;
                    tx_word <= codeword_a_bits;
                    if (select_start) begin
                        tx_state <= tx_codeword_select == SELECT_A_LOOP ?
                                    TX_LOOP_A : TX_SEND_A;
                    end
                end
                TX_SEND_A, TX_LOOP_A: begin
                    if (frame_end) begin
                        tx_reps <= reps_done ? tx_reps : tx_reps + 4'h1;
                        if (tx_state == TX_LOOP_A) begin
                            if (reps_done &&
                                tx_codeword_select == SELECT_IDLE)
                                tx_state <= TX_IDLE;
                        end else if (reps_done) begin
                            tx_reps <= 4'h0;
                            if (tx_codeword_select == SELECT_A_THEN_B ||
                                select_mode_b) begin
                                tx_state <= TX_SEND_B;
                                tx_word <= codeword_b_bits;
                            end else tx_state <= TX_IDLE;
                        end
                    end
                end
                TX_SEND_B: begin
                    if (frame_end) begin
                        tx_reps <= tx_reps + 4'h1;
                        if (reps_done) tx_state <= TX_IDLE;
                    end
                end
                default: tx_state <= TX_IDLE;
            endcase
        end
    end

    // remembers that the running action was started as a then b
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) select_mode_b <= 1'b0;
        else if (select_start)
            select_mode_b <= tx_codeword_select == SELECT_A_THEN_B;
    end

    // ****************************************
    // receiver
    // ****************************************
    logic rx_s1;
    logic rx_s2;
    logic rx_s3;
    logic rx_level;
    logic [15:0] rx_shift;
    logic [5:0] cand_word;
    logic [1:0] cand_count;
    logic [5:0] valid_word;
    logic rx_codeword_detected;
    logic [1:0] diff_count;
    logic [4:0] ones_run;
    logic rx_idle;
    logic reset_prev;
    logic [3:0] rx_since;
    wire rx_flush = rx_reset_bit && !reset_prev;
    wire [15:0] next_shift = {rx_level, rx_shift[15:1]};
    wire shape_ok = next_shift[7:0] == 8'hff && !next_shift[8] &&
                    !next_shift[15];
    wire found = bit_enable && shape_ok && rx_since == 4'h0;
    wire [5:0] found_word = next_shift[14:9];
    wire validate = found && found_word == cand_word &&
                    cand_count == VALID_COUNT - 2'h1 &&
                    !rx_codeword_detected;
    wire queue_full;
    wire rx_queue_empty;
    wire [5:0] rx_codeword_bits;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_s1 <= 1'b1;
            rx_s2 <= 1'b1;
            rx_s3 <= 1'b1;
            rx_level <= 1'b1;
        end else begin
            rx_s1 <= rx_bit;
            rx_s2 <= rx_s1;
            rx_s3 <= rx_s2;
            if (rx_s2 == rx_s3) rx_level <= rx_s3;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_shift <= 16'h0000;
            cand_word <= RESET_WORD;
            // top count marks no candidate yet
            cand_count <= VALID_COUNT + 2'h1;
            valid_word <= RESET_WORD;
            rx_codeword_detected <= 1'b0;
            diff_count <= 2'h0;
            ones_run <= 5'h00;
            rx_idle <= 1'b0;
            reset_prev <= 1'b0;
            rx_since <= 4'h0;
        end else begin
            reset_prev <= rx_reset_bit;
            if (rx_flush) begin
                rx_shift <= 16'h0000;
                cand_count <= VALID_COUNT + 2'h1;
                rx_codeword_detected <= 1'b0;
                rx_idle <= 1'b0;
                ones_run <= 5'h00;
                diff_count <= 2'h0;
            end else if (bit_enable) begin
                rx_shift <= next_shift;
                if (rx_since != 4'h0) rx_since <= rx_since + 4'h1;
                ones_run <= !rx_level ? 5'h00 :
                            (ones_run == IDLE_ONES ? ones_run :
                             ones_run + 5'h01);
                if (ones_run == IDLE_ONES - 5'h01 && rx_level) rx_idle <= 1'b1;
                if (found) begin
                    rx_since <= 4'h1;
                    if (found_word == cand_word && cand_count != VALID_COUNT)
                        cand_count <= cand_count + 2'h1;
                    else if (found_word != cand_word) begin
                        cand_word <= found_word;
                        cand_count <= 2'h0;
                    end
                    if (validate) begin
                        valid_word <= found_word;
                        rx_codeword_detected <= 1'b1;
                        rx_idle <= 1'b0;
                    end
                    if (rx_codeword_detected && found_word != valid_word) begin
                        diff_count <= diff_count + 2'h1;
                        if (diff_count == 2'h1) rx_codeword_detected <= 1'b0;
                    end else diff_count <= 2'h0;
                end
            end
        end
    end

    feac_rx_queue u_queue (
        .clk(clk),
        .rst_n(rst_n),
        .flush(rx_flush),
        .push(validate),
        .push_word(found_word),
        .pop(rd_head),
        .head_word(rx_codeword_bits),
        .empty(rx_queue_empty),
        .full(queue_full)
    );

    // ****************************************
    // latched status and interrupt
    // ****************************************
    logic [3:0] status_prev;
    wire [3:0] status_now = {!rx_queue_empty, rx_idle,
                             rx_codeword_detected, !tx_busy};
    wire overflow = validate && queue_full;
    wire [4:0] set_mask = {overflow, status_now & ~status_prev};
    wire [4:0] next_latched = (alarm_code_latched_status & ~clear_mask) |
                              set_mask;
    wire next_master = wr_master ? reg_wdata[0] : alarm_code_master_irq_en;
    wire [4:0] next_enable = wr_enable ? reg_wdata[4:0] :
                             alarm_code_irq_enable;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            status_prev <= 4'h1;
            alarm_code_latched_status <= 5'h00;
            irq <= 1'b0;
        end else begin
            status_prev <= status_now;
            alarm_code_latched_status <= next_latched;
            irq <= next_master && |(next_latched & next_enable);
        end
    end

    // ****************************************
    // read data
    // ****************************************
    wire [7:0] status_byte = {4'h0, rx_queue_empty, rx_idle,
                              rx_codeword_detected, !tx_busy};
    logic [7:0] read_mux;
    always_comb begin
        case (reg_addr)
            ADDR_CONTROL: read_mux = {5'h00, rx_reset_bit, tx_codeword_select};
            ADDR_STATUS: read_mux = status_byte;
            ADDR_LATCHED: read_mux = {3'h0, alarm_code_latched_status};
            ADDR_IRQ_ENABLE: read_mux = {3'h0, alarm_code_irq_enable};
            ADDR_CODEWORD_A: read_mux = {2'h0, codeword_a_bits};
            ADDR_CODEWORD_B: read_mux = {2'h0, codeword_b_bits};
            ADDR_RX_HEAD: read_mux = {2'h0, rx_codeword_bits};
            ADDR_MASTER_IRQ: read_mux = {7'h00, alarm_code_master_irq_en};
            default: read_mux = RESET_BYTE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) reg_rdata <= RESET_BYTE;
        else if (reg_read) reg_rdata <= read_mux;
        else reg_rdata <= RESET_BYTE;
    end

    // ****************************************
    // checks
    // ****************************************
    property p_overflow_sets;
        @(posedge clk) disable iff (!rst_n)
        overflow |=> alarm_code_latched_status[BIT_RX_OVERFLOW];
    endproperty
    a_overflow_sets: assert property (p_overflow_sets)
        else $error("overflow latch not set");

    property p_overflow_clear;
        @(posedge clk) disable iff (!rst_n)
        wr_latched && reg_wdata[4] && !overflow |=>
            !alarm_code_latched_status[BIT_RX_OVERFLOW];
    endproperty
    a_overflow_clear: assert property (p_overflow_clear)
        else $error("overflow latch not cleared");

    property p_irq_level;
        @(posedge clk) disable iff (!rst_n)
        ##1 irq == (alarm_code_master_irq_en &&
            |(alarm_code_latched_status & alarm_code_irq_enable));
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("interrupt level wrong");

    property p_enable_write;
        @(posedge clk) disable iff (!rst_n)
        wr_enable |=> alarm_code_irq_enable == $past(reg_wdata[4:0]);
    endproperty
    a_enable_write: assert property (p_enable_write)
        else $error("enable register not written");

    property p_idle_ones;
        @(posedge clk) disable iff (!rst_n)
        !tx_busy && bit_enable |=> tx_bit;
    endproperty
    a_idle_ones: assert property (p_idle_ones)
        else $error("idle line not ones");

    property p_head_read;
        @(posedge clk) disable iff (!rst_n)
        rd_head |=> reg_rdata == {2'h0, $past(rx_codeword_bits)};
    endproperty
    a_head_read: assert property (p_head_read)
        else $error("queue head read wrong");

    property p_start;
        @(posedge clk) disable iff (!rst_n)
        select_start && !tx_busy |=> tx_busy;
    endproperty
    a_start: assert property (p_start)
        else $error("select change did not start");

    property p_empty_status;
        @(posedge clk) disable iff (!rst_n)
        rx_queue_empty |-> !alarm_code_latched_status[BIT_RX_NONEMPTY] ||
            $past(!rx_queue_empty) || $past(alarm_code_latched_status[3]);
    endproperty
    a_empty_status: assert property (p_empty_status)
        else $error("nonempty latch without data");

    c_validate: cover property (@(posedge clk) validate);
    c_overflow: cover property (@(posedge clk) overflow);
    c_send_b: cover property (@(posedge clk) tx_state == TX_SEND_B);
    c_irq: cover property (@(posedge clk) irq);
endmodule // feac_ctrl

/* File: testbench/feac_far_end.sv */
// far-end terminal model: sends codewords, watches the transmit stream
module feac_far_end
    import feac_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // job control
    input wire logic [3:0] gap,
    input wire logic send,
    input wire logic [29:0] words,
    input wire logic [2:0] nwords,
    input wire logic [3:0] reps,
    output logic busy,
    // channel
    output logic bit_enable,
    output logic rx_bit,
    input wire logic tx_bit,
    // transmit watch
    input wire logic [15:0] watch_a,
    input wire logic [15:0] watch_b,
    output logic [7:0] hits_a,
    output logic [7:0] hits_b
);
    logic [3:0] cnt;
    logic [3:0] bitn;
    logic [3:0] rep;
    logic [2:0] idx;
    logic [15:0] sh;
    logic [15:0] next_sh;
    logic [5:0] word;
    logic [15:0] frame;
    assign word = words[6*idx +: 6];
    assign frame = {1'b0, word, 1'b0, 8'hff};
    assign next_sh = {tx_bit, sh[15:1]};
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt <= 4'h0;
            bit_enable <= 1'b0;
            busy <= 1'b0;
            rx_bit <= 1'b1;
            bitn <= 4'h0;
            rep <= 4'h0;
            idx <= 3'h0;
            sh <= 16'hffff;
            hits_a <= 8'h00;
            hits_b <= 8'h00;
        end else begin
            cnt <= (cnt >= gap) ? 4'h0 : cnt + 4'h1;
            bit_enable <= (cnt >= gap);
            if (send) begin
                busy <= 1'b1;
                bitn <= 4'h0;
                rep <= 4'h0;
                idx <= 3'h0;
            end else if (bit_enable) begin
                sh <= next_sh;
                hits_a <= hits_a + {7'h00, next_sh == watch_a};
                hits_b <= hits_b + {7'h00, next_sh == watch_b};
                rx_bit <= busy ? frame[bitn] : 1'b1;
                if (busy) begin
                    bitn <= bitn + 4'h1;
                    if (bitn == 4'hf) begin
                        rep <= (rep == reps - 4'h1) ? 4'h0 : rep + 4'h1;
                        if (rep == reps - 4'h1) begin
                            idx <= idx + 3'h1;
                            busy <= (idx != nwords - 3'h1);
                        end
                    end
                end
            end
        end
    end
endmodule // feac_far_end

/* File: testbench/feac_ctrl_test.sv */
// self-checking bench for the alarm codeword controller
module feac_ctrl_test
    import feac_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [7:0] reg_rdata;
    logic bit_enable, rx_bit, tx_bit, irq, busy;
    logic [3:0] gap = 4'h3;
    logic send = 1'b0;
    logic [29:0] words = 30'h0;
    logic [2:0] nwords = 3'h1;
    logic [3:0] reps = 4'h1;
    logic [7:0] hits_a, hits_b, ha, hb;
    logic [15:0] pat_a = {1'b0, 6'h2b, 1'b0, 8'hff};
    logic [15:0] pat_b = {1'b0, 6'h15, 1'b0, 8'hff};
    int error_cnt = 0;
    int checks = 0;
    always #5 clk = ~clk;
    feac_ctrl dut (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .bit_enable(bit_enable), .rx_bit(rx_bit),
        .tx_bit(tx_bit), .irq(irq));
    feac_far_end far_end (.clk(clk), .reset_n(reset_n), .gap(gap),
        .send(send), .words(words), .nwords(nwords), .reps(reps),
        .busy(busy), .bit_enable(bit_enable), .rx_bit(rx_bit),
        .tx_bit(tx_bit), .watch_a(pat_a), .watch_b(pat_b),
        .hits_a(hits_a), .hits_b(hits_b));
    // ****************
    // shared tasks
    // ****************
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask
    task automatic chk_rd(input logic [7:0] a, input logic [7:0] m,
                          input logic [7:0] exp);
        @(posedge clk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_read <= 1'b0;
        #1 check(reg_rdata & m, exp);
    endtask
    task automatic chk_irq(input logic exp);
        repeat (3) @(posedge clk);
        #1 check({7'h00, irq}, {7'h00, exp});
    endtask
    task automatic frames(input int n);
        repeat (n * 64) @(posedge clk);
    endtask
    task automatic rx_job(input logic [29:0] w, input logic [2:0] n,
                          input logic [3:0] r);
        @(posedge clk);
        words <= w;
        nwords <= n;
        reps <= r;
        send <= 1'b1;
        @(posedge clk);
        send <= 1'b0;
        #1;
        for (int i = 0; i < 4000 && busy !== 1'b0; i++) @(posedge clk);
        check({7'h00, busy}, 8'h00);
        repeat (80) @(posedge clk);
    endtask
    // ****************
    // scenarios
    // ****************
    task automatic t_reset;
        chk_rd(ADDR_CONTROL, 8'hff, RESET_BYTE);
        chk_rd(ADDR_IRQ_ENABLE, 8'hff, RESET_BYTE);
        chk_rd(ADDR_CODEWORD_A, 8'hff, RESET_BYTE);
        chk_rd(ADDR_CODEWORD_B, 8'hff, RESET_BYTE);
        chk_rd(ADDR_MASTER_IRQ, 8'hff, RESET_BYTE);
        chk_rd(8'h70, 8'hff, 8'h00);
        chk_rd(ADDR_STATUS, 8'h08, 8'h08);
    endtask
    task automatic t_irq_gate;
        wr(ADDR_IRQ_ENABLE, 8'hff);
        chk_rd(ADDR_IRQ_ENABLE, 8'hff, 8'h1f);
        wr(ADDR_IRQ_ENABLE, 8'h00);
        wr(ADDR_MASTER_IRQ, 8'h01);
        chk_irq(1'b0);
        wr(ADDR_IRQ_ENABLE, 8'h01);
        chk_irq(1'b1);
        wr(ADDR_LATCHED, 8'h01);
        chk_irq(1'b0);
        wr(ADDR_MASTER_IRQ, 8'h00);
        wr(ADDR_IRQ_ENABLE, 8'h00);
    endtask
    task automatic t_tx_once;
        wr(ADDR_CODEWORD_A, 8'h2b);
        wr(ADDR_CODEWORD_B, 8'h15);
        chk_rd(ADDR_CODEWORD_A, 8'hff, 8'h2b);
        chk_rd(ADDR_CODEWORD_B, 8'hff, 8'h15);
        ha = hits_a;
        hb = hits_b;
        wr(ADDR_CONTROL, 8'h01);
        frames(12);
        check(hits_a - ha, 8'h0a);
        check(hits_b - hb, 8'h00);
        wr(ADDR_CONTROL, 8'h00);
    endtask
    task automatic t_tx_a_then_b;
        ha = hits_a;
        hb = hits_b;
        wr(ADDR_CONTROL, 8'h02);
        frames(22);
        check(hits_a - ha, 8'h0a);
        check(hits_b - hb, 8'h0a);
        wr(ADDR_CONTROL, 8'h00);
    endtask
    task automatic t_tx_loop;
        ha = hits_a;
        wr(ADDR_CONTROL, 8'h03);
        frames(15);
        check({7'h00, (hits_a - ha) >= 8'h0c}, 8'h01);
        wr(ADDR_CONTROL, 8'h00);
        frames(2);
        ha = hits_a;
        frames(3);
        check(hits_a - ha, 8'h00);
    endtask
    task automatic t_rx_validate;
        gap <= 4'h7;
        rx_job({24'h0, 6'h0d}, 3'h1, 4'h2);
        chk_rd(ADDR_STATUS, 8'h08, 8'h08);
        rx_job({24'h0, 6'h32}, 3'h1, 4'h5);
        chk_rd(ADDR_STATUS, 8'h08, 8'h00);
        chk_rd(ADDR_RX_HEAD, 8'hff, 8'h32);
        chk_rd(ADDR_STATUS, 8'h08, 8'h08);
    endtask
    task automatic t_rx_overflow;
        rx_job({6'h3e, 6'h34, 6'h23, 6'h12, 6'h01}, 3'h5, 4'h3);
        chk_rd(ADDR_LATCHED, 8'h10, 8'h10);
        chk_rd(ADDR_RX_HEAD, 8'hff, 8'h01);
        chk_rd(ADDR_RX_HEAD, 8'hff, 8'h12);
        chk_rd(ADDR_RX_HEAD, 8'hff, 8'h23);
        chk_rd(ADDR_RX_HEAD, 8'hff, 8'h34);
        chk_rd(ADDR_STATUS, 8'h08, 8'h08);
        wr(ADDR_MASTER_IRQ, 8'h01);
        wr(ADDR_IRQ_ENABLE, 8'h10);
        chk_irq(1'b1);
        wr(ADDR_MASTER_IRQ, 8'h00);
        chk_irq(1'b0);
        wr(ADDR_MASTER_IRQ, 8'h01);
        chk_irq(1'b1);
        wr(ADDR_LATCHED, 8'h10);
        chk_irq(1'b0);
        chk_rd(ADDR_LATCHED, 8'h10, 8'h00);
        rx_job({24'h0, 6'h2a}, 3'h1, 4'h3);
        chk_rd(ADDR_STATUS, 8'h08, 8'h00);
        wr(ADDR_CONTROL, 8'h04);
        chk_rd(ADDR_STATUS, 8'h08, 8'h08);
        wr(ADDR_CONTROL, 8'h00);
    endtask
    task automatic print_verdict;
        if (error_cnt == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge clk);
        error_cnt++;
        print_verdict();
    end
    initial begin
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk);
        t_reset();
        t_tx_once();
        t_irq_gate();
        t_tx_a_then_b();
        t_tx_loop();
        t_rx_validate();
        t_rx_overflow();
        print_verdict();
    end
endmodule // feac_ctrl_test
